// File: design/s0d_pkg.sv
package s0d_pkg;
   // Register map: page register at a seven-bit address on both pages, ratio registers at full eight-bit addresses
   localparam logic [6:0] PAGE_ADDR = 7'h7F;
   localparam logic [7:0] OFS_A = 8'h80;
   localparam logic [7:0] OFS_B = 8'h83;
   localparam logic [7:0] OFS_C = 8'h86;
   localparam logic [7:0] OFS_D = 8'h89;
   localparam logic [7:0] OFS_END = 8'h8C;
   localparam int REG_BYTES = 3;
   localparam logic [1:0] LAST_BYTE = 2'h2;
   // Reset values
   localparam logic [23:0] RST_AB = 24'h000002;
   localparam logic [23:0] RST_CD = 24'h000040;
   localparam logic RST_PAGE = 1'b0;
   // Field positions
   localparam int PAGE_BIT = 0;
   localparam int MODE_LSB = 20;
   localparam int TYPE_BIT = 19;
   localparam int POL_BIT = 18;
   localparam int SEL_LSB = 16;
   localparam int AB_RATIO_W = 23;
   localparam logic [3:0] MODE_FRAME = 4'hF;
   // Related clock selector codes
   localparam logic [1:0] SEL_A = 2'h0;
   localparam logic [1:0] SEL_B = 2'h1;
   localparam logic [1:0] SEL_C = 2'h2;
   localparam logic [1:0] SEL_D = 2'h3;
   // Smallest ratio a flop-based divider can make
   localparam logic [23:0] MIN_RATIO = 24'h000002;
   // Frame pulse generator states
   typedef enum logic {
      FP_LOW = 1'b0,
      FP_HIGH = 1'b1
   } s0d_fp_state_t;
endpackage

// File: design/s0d_div.sv
`timescale 1ns/10ps
module s0d_div
   import s0d_pkg::*;
#(
   parameter int W = 24,
   parameter logic [23:0] RATIO_RST = 24'h000002
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Ratio, committed whole by the register file
   input wire logic [W-1:0] ratio,
   // Divided clock and its edge strobes
   output logic clk_q,
   output logic rise_q,
   output logic fall_q
);
   logic [W-1:0] cnt_q, cnt_d;
   logic [W-1:0] ratio_q, ratio_d;
   logic clk_d, rise_d, fall_d;
   logic [W-1:0] eff, r_use;
   logic wrap;

   // Ratio taken only at period end, so a new value never cuts a half-cycle short
   always_comb begin
      eff = (ratio < W'(MIN_RATIO)) ? W'(MIN_RATIO) : ratio;
      wrap = (cnt_q >= ratio_q - W'(1));
      cnt_d = wrap ? '0 : cnt_q + W'(1);
      ratio_d = wrap ? eff : ratio_q;
      r_use = ratio_d;
      // High for the rounded-up half; odd ratios lean one input cycle high
      clk_d = (cnt_d < (r_use - (r_use >> 1)));
      rise_d = clk_d & ~clk_q;
      fall_d = ~clk_d & clk_q;
   end

   // Counter and output flops
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cnt_q <= '0;
         ratio_q <= W'(RATIO_RST);
         clk_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ratio_q <= ratio_d;
         clk_q <= clk_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end
endmodule

// File: design/s0d_frm.sv
`timescale 1ns/10ps
module s0d_frm
   import s0d_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Frame settings
   input wire logic run,
   input wire logic [15:0] period,
   input wire logic edge_type,
   input wire logic invert,
   // Related clock edges
   input wire logic rel_rise,
   input wire logic rel_fall,
   // Shaped pulse
   output logic pulse_q
);
   s0d_fp_state_t st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic pulse_d;
   logic [15:0] per;
   logic last;

   // Boundary sits on the related rising edge where the count wraps
   always_comb begin
      per = (period == 16'h0000) ? 16'h0001 : period;
      last = (cnt_q == per - 16'h0001);
      cnt_d = cnt_q;
      st_d = st_q;
      if (!run) begin
         cnt_d = '0;
         st_d = FP_LOW;
      end else begin
         if (rel_rise) begin
            cnt_d = last ? 16'h0000 : cnt_q + 16'h0001;
         end
         if (edge_type) begin
            // Edge framing: one related period starting at the boundary
            if (rel_rise) begin
               st_d = last ? FP_HIGH : FP_LOW;
            end
         end else if (rel_fall) begin
            // Mid framing: falling edge to falling edge around the boundary
            st_d = last ? FP_HIGH : FP_LOW;
         end
      end
      pulse_d = (st_d == FP_HIGH) ^ invert;
   end

   // State and output flops
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st_q <= FP_LOW;
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end
endmodule

// File: design/s0d_top.sv
`timescale 1ns/10ps
module s0d_top
   import s0d_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Serial-port register access, seven address bits
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   // Current page
   output logic page_sel_q,
   // Routing of frame pulses to configurable pins
   input wire logic route_c_cfg_pin,
   input wire logic route_d_cfg_pin,
   // Divider outputs
   output logic out_a_q,
   output logic out_b_q,
   output logic out_c_q,
   output logic out_d_q
);
   // Decoded register slot: valid flag, register index, byte within it
   typedef struct packed {
      logic hit;
      logic [1:0] idx;
      logic [1:0] byte_sel;
   } s0d_slot_t;

   // Map a full eight-bit address onto a ratio register byte
   function automatic s0d_slot_t decode(input logic [7:0] full);
      s0d_slot_t s;
      logic [7:0] rel;
      s = '0;
      rel = full - OFS_A;
      if (full >= OFS_A && full < OFS_END) begin
         s.hit = 1'b1;
         s.idx = 2'(rel / 8'(REG_BYTES));
         s.byte_sel = 2'(rel % 8'(REG_BYTES));
      end
      return s;
   endfunction

   // Reset value of a ratio register
   function automatic logic [23:0] rst_val(input int i);
      return (i < 2) ? RST_AB : RST_CD;
   endfunction

   logic page_q, page_d;
   logic [23:0] shadow_q [4];
   logic [23:0] shadow_d [4];
   logic [23:0] live_q [4];
   logic [23:0] live_d [4];
   logic [7:0] rdata_d;
   logic [7:0] full_addr;
   logic page_hit;
   s0d_slot_t slot;

   // Address formation
   // page extends address
   always_comb begin
      page_hit = (reg_addr == PAGE_ADDR);
      full_addr = {page_q, reg_addr};
      slot = page_hit ? s0d_slot_t'('0) : decode(full_addr);
   end

   // Register writes and whole-value commit
   always_comb begin
      page_d = page_q;
      for (int i = 0; i < 4; i++) begin
         shadow_d[i] = shadow_q[i];
         live_d[i] = live_q[i];
      end
      if (reg_wr && page_hit) begin
         page_d = reg_wdata[PAGE_BIT];
      end
      if (reg_wr && slot.hit) begin
         // Lowest address holds bits 7:0
         shadow_d[slot.idx][slot.byte_sel*8 +: 8] = reg_wdata;
         if (slot.byte_sel == LAST_BYTE) begin
            live_d[slot.idx] = shadow_d[slot.idx];
         end
      end
   end

   // Read data: bytes as written, reserved page bits as zero
   always_comb begin
      rdata_d = reg_rdata_q;
      if (reg_rd) begin
         rdata_d = 8'h00;
         if (page_hit) begin
            rdata_d[PAGE_BIT] = page_q;
         end else if (slot.hit) begin
            rdata_d = shadow_q[slot.idx][slot.byte_sel*8 +: 8];
         end
      end
   end

   // Register file flops
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         page_q <= RST_PAGE;
         reg_rdata_q <= 8'h00;
         for (int i = 0; i < 4; i++) begin
            shadow_q[i] <= rst_val(i);
            live_q[i] <= rst_val(i);
         end
      end else begin
         page_q <= page_d;
         reg_rdata_q <= rdata_d;
         for (int i = 0; i < 4; i++) begin
            shadow_q[i] <= shadow_d[i];
            live_q[i] <= live_d[i];
         end
      end
   end

   // Divider bank: A, B, C, D in index order
   logic [3:0] dclk, drise, dfall;
   logic [23:0] dratio [4];

   // A and B use 23 bits; bit 23 ignored
   always_comb begin
      dratio[0] = {1'b0, live_q[0][AB_RATIO_W-1:0]};
      dratio[1] = {1'b0, live_q[1][AB_RATIO_W-1:0]};
      // C and D use the full word in clock mode
      // A frame word is no ratio; parking at reset ratio keeps a later return quick
      dratio[2] = (live_q[2][MODE_LSB +: 4] == MODE_FRAME) ? RST_CD : live_q[2];
      dratio[3] = (live_q[3][MODE_LSB +: 4] == MODE_FRAME) ? RST_CD : live_q[3];
   end

   s0d_div #(.W(24), .RATIO_RST(RST_AB)) u_div_a (
      .mclk(mclk),
      .reset_n(reset_n),
      .ratio(dratio[0]),
      .clk_q(dclk[0]),
      .rise_q(drise[0]),
      .fall_q(dfall[0])
   );

   s0d_div #(.W(24), .RATIO_RST(RST_AB)) u_div_b (
      .mclk(mclk),
      .reset_n(reset_n),
      .ratio(dratio[1]),
      .clk_q(dclk[1]),
      .rise_q(drise[1]),
      .fall_q(dfall[1])
   );

   s0d_div #(.W(24), .RATIO_RST(RST_CD)) u_div_c (
      .mclk(mclk),
      .reset_n(reset_n),
      .ratio(dratio[2]),
      .clk_q(dclk[2]),
      .rise_q(drise[2]),
      .fall_q(dfall[2])
   );

   s0d_div #(.W(24), .RATIO_RST(RST_CD)) u_div_d (
      .mclk(mclk),
      .reset_n(reset_n),
      .ratio(dratio[3]),
      .clk_q(dclk[3]),
      .rise_q(drise[3]),
      .fall_q(dfall[3])
   );

   // Frame mode decode and related-clock steering for C and D
   logic frm_c, frm_d;
   logic rel_rise_c, rel_fall_c, rel_rise_d, rel_fall_d;
   logic pulse_c, pulse_d;

   always_comb begin
      frm_c = (live_q[2][MODE_LSB +: 4] == MODE_FRAME);
      frm_d = (live_q[3][MODE_LSB +: 4] == MODE_FRAME);
   end

   // C related clock; reserved gives none
   always_comb begin
      case (live_q[2][SEL_LSB +: 2])
         SEL_A: begin
            rel_rise_c = drise[0];
            rel_fall_c = dfall[0];
         end
         SEL_B: begin
            rel_rise_c = drise[1];
            rel_fall_c = dfall[1];
         end
         SEL_D: begin
            rel_rise_c = drise[3];
            rel_fall_c = dfall[3];
         end
         default: begin
            rel_rise_c = 1'b0;
            rel_fall_c = 1'b0;
         end
      endcase
   end

   // D related clock; reserved gives none
   always_comb begin
      case (live_q[3][SEL_LSB +: 2])
         SEL_A: begin
            rel_rise_d = drise[0];
            rel_fall_d = dfall[0];
         end
         SEL_B: begin
            rel_rise_d = drise[1];
            rel_fall_d = dfall[1];
         end
         SEL_C: begin
            rel_rise_d = drise[2];
            rel_fall_d = dfall[2];
         end
         default: begin
            rel_rise_d = 1'b0;
            rel_fall_d = 1'b0;
         end
      endcase
   end

   s0d_frm u_frm_c (
      .mclk(mclk),
      .reset_n(reset_n),
      // reserved selector rests at inactive level
      .run(frm_c && (live_q[2][SEL_LSB +: 2] != SEL_C)),
      .period(live_q[2][15:0]),
      .edge_type(live_q[2][TYPE_BIT]),
      .invert(live_q[2][POL_BIT] ^ route_c_cfg_pin),
      .rel_rise(rel_rise_c),
      .rel_fall(rel_fall_c),
      .pulse_q(pulse_c)
   );

   s0d_frm u_frm_d (
      .mclk(mclk),
      .reset_n(reset_n),
      // reserved selector rests at inactive level
      .run(frm_d && (live_q[3][SEL_LSB +: 2] != SEL_D)),
      .period(live_q[3][15:0]),
      .edge_type(live_q[3][TYPE_BIT]),
      .invert(live_q[3][POL_BIT] ^ route_d_cfg_pin),
      .rel_rise(rel_rise_d),
      .rel_fall(rel_fall_d),
      .pulse_q(pulse_d)
   );

   // Output stage; one flop so pins never see mux glitches
   logic out_a_d, out_b_d, out_c_d, out_d_d;

   always_comb begin
      out_a_d = dclk[0];
      out_b_d = dclk[1];
      out_c_d = frm_c ? pulse_c : dclk[2];
      out_d_d = frm_d ? pulse_d : dclk[3];
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         out_c_q <= 1'b0;
         out_d_q <= 1'b0;
         page_sel_q <= RST_PAGE;
      end else begin
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         out_c_q <= out_c_d;
         out_d_q <= out_d_d;
         page_sel_q <= page_d;
      end
   end
endmodule

// File: dv/s0d_top_assertions.sv
`timescale 1ns/10ps
module s0d_chk
   import s0d_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register access
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_q,
   input wire logic page_sel_q,
   // Outputs
   input wire logic out_a_q,
   input wire logic out_b_q,
   input wire logic out_c_q,
   input wire logic out_d_q
);
   logic [15:0] sh_q;
   logic [22:0] new_q;
   logic [22:0] old_q;
   logic [23:0] hi_q;
   logic [23:0] lo_q;
   logic up_q;
   logic dn_q;
   logic upw;
   assign upw = reg_wr && page_sel_q;
   // Ratios below two run as two
   function automatic logic [23:0] hi_of(input logic [22:0] n);
      return (n < 23'h000002) ? 24'h000001 : ({1'b0, n} + 24'h000001) >> 1;
   endfunction
   function automatic logic [23:0] lo_of(input logic [22:0] n);
      return (n < 23'h000002) ? 24'h000001 : {1'b0, n} >> 1;
   endfunction
   // Old and new ratio both kept, as the divider adopts at period end
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sh_q <= RST_AB[15:0];
         new_q <= RST_AB[22:0];
         old_q <= RST_AB[22:0];
         hi_q <= 24'h000000;
         lo_q <= 24'h000000;
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         if (upw && reg_addr == 7'h00) sh_q[7:0] <= reg_wdata;
         if (upw && reg_addr == 7'h01) sh_q[15:8] <= reg_wdata;
         if (upw && reg_addr == 7'h02) begin
            old_q <= new_q;
            new_q <= {reg_wdata[6:0], sh_q};
         end
         hi_q <= out_a_q ? hi_q + 24'h000001 : 24'h000000;
         lo_q <= out_a_q ? 24'h000000 : lo_q + 24'h000001;
         if ($rose(out_a_q)) up_q <= 1'b1;
         if ($fell(out_a_q)) dn_q <= 1'b1;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_page_write: assert property (reg_wr && reg_addr == PAGE_ADDR
      |=> page_sel_q == $past(reg_wdata[0])) else $error("page bit wrong");
   a_page_steady: assert property (!(reg_wr && reg_addr == PAGE_ADDR)
      |=> $stable(page_sel_q)) else $error("page bit moved");
   a_page_readback: assert property (reg_rd && reg_addr == PAGE_ADDR
      |=> reg_rdata_q == {7'h00, $past(page_sel_q)}) else $error("page read wrong");
   a_lower_page_zero: assert property (reg_rd && !page_sel_q && reg_addr != PAGE_ADDR
      |=> reg_rdata_q == 8'h00) else $error("lower page read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
      else $error("read byte moved");
   a_high_run_a: assert property ($fell(out_a_q) && up_q
      |-> hi_q == hi_of(new_q) || hi_q == hi_of(old_q)) else $error("A high run wrong");
   a_low_run_a: assert property ($rose(out_a_q) && dn_q
      |-> lo_q == lo_of(new_q) || lo_q == lo_of(old_q)) else $error("A low run wrong");
   a_reset_quiet: assert property ($rose(reset_n)
      |-> !(out_a_q || out_b_q || out_c_q || out_d_q || page_sel_q)) else $error("not quiet");
   c_page_set: cover property (reg_wr && reg_addr == PAGE_ADDR ##1 page_sel_q);
   c_a_period: cover property ($fell(out_a_q) && up_q);
   c_upper_read: cover property (reg_rd && page_sel_q && reg_addr < 7'h0C);
endmodule
bind s0d_top s0d_chk u_chk (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .page_sel_q(page_sel_q),
   .out_a_q(out_a_q), .out_b_q(out_b_q), .out_c_q(out_c_q), .out_d_q(out_d_q));

// File: dv/s0d_sink.sv
`timescale 1ns/10ps
module s0d_sink (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Observed pin
   input wire logic pin,
   // Last closed runs and rising edges
   output logic [15:0] hi_len_q,
   output logic [15:0] lo_len_q,
   output logic [15:0] rises_q
);
   logic pin_q;
   logic [15:0] run_q;
   // Runs are stored only when closed, so a half-seen run never counts
   always @(posedge mclk) begin
      if (!reset_n) begin
         pin_q <= 1'b0;
         run_q <= 16'h0000;
         hi_len_q <= 16'h0000;
         lo_len_q <= 16'h0000;
         rises_q <= 16'h0000;
      end else if (pin != pin_q) begin
         pin_q <= pin;
         run_q <= 16'h0001;
         if (pin_q) hi_len_q <= run_q;
         else lo_len_q <= run_q;
         if (pin) rises_q <= rises_q + 16'h0001;
      end else begin
         run_q <= run_q + 16'h0001;
      end
   end
endmodule

// File: dv/synth0_output_dividers_framepulse_tb.sv
`timescale 1ns/10ps
module synth0_output_dividers_framepulse_tb;
   import s0d_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic route_c = 1'b0;
   logic route_d = 1'b0;
   logic [7:0] rdata;
   logic page;
   logic [3:0] outs;
   logic [3:0][15:0] hi_len;
   logic [3:0][15:0] lo_len;
   logic [3:0][15:0] rises;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   initial forever #12.5 mclk = ~mclk;
   s0d_top u_dut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .page_sel_q(page),
      .route_c_cfg_pin(route_c), .route_d_cfg_pin(route_d), .out_a_q(outs[0]),
      .out_b_q(outs[1]), .out_c_q(outs[2]), .out_d_q(outs[3]));
   // One clocked device on each output pin
   for (genvar i = 0; i < 4; i++) begin : g_sink
      s0d_sink u_sink (.mclk(mclk), .reset_n(reset_n), .pin(outs[i]), .hi_len_q(hi_len[i]),
         .lo_len_q(lo_len[i]), .rises_q(rises[i]));
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("byte %0h", a), {24'h000000, rdata}, {24'h000000, e});
   endtask
   // Low byte first; the top byte commits the whole value
   task automatic wr24(input logic [6:0] a, input logic [23:0] v);
      wr(a, v[7:0]);
      wr(a + 7'h01, v[15:8]);
      wr(a + 7'h02, v[23:16]);
   endtask
   task automatic rd24(input logic [6:0] a, input logic [23:0] e);
      rd(a, e[7:0]);
      rd(a + 7'h01, e[15:8]);
      rd(a + 7'h02, e[23:16]);
   endtask
   // Long enough for two whole frames of the slowest setting
   task automatic runs(input int p, input logic [15:0] h, input logic [15:0] l);
      repeat (300) @(posedge mclk);
      #1;
      chk($sformatf("high run %0d", p), {16'h0000, hi_len[p]}, {16'h0000, h});
      chk($sformatf("low run %0d", p), {16'h0000, lo_len[p]}, {16'h0000, l});
   endtask
   // Three related periods per frame, pulse one related period wide
   task automatic frame(input bit d, input logic [1:0] s, input logic pol, input logic rt,
                        input logic ty, input logic [15:0] w);
      wr24(d ? OFS_D[6:0] : OFS_C[6:0], {MODE_FRAME, ty, pol, s, 16'h0003});
      if (d) route_d <= rt;
      else route_c <= rt;
      runs(d ? 3 : 2, (pol ^ rt) ? w + w : w, (pol ^ rt) ? w : w + w);
   endtask
   task automatic close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Whole run needs about 4600 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 12000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      logic [15:0] snap;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      rd(PAGE_ADDR, 8'h00);
      rd(7'h00, 8'h00);
      wr(PAGE_ADDR, 8'hFF);
      rd(PAGE_ADDR, 8'h01);
      rd24(OFS_A[6:0], RST_AB);
      rd24(OFS_B[6:0], RST_AB);
      rd24(OFS_C[6:0], RST_CD);
      rd24(OFS_D[6:0], RST_CD);
      wr(7'h0C, 8'h5A);
      rd(7'h0C, 8'h00);
      runs(0, 16'h0001, 16'h0001);
      runs(2, 16'h0020, 16'h0020);
      $display("test reset_paging done");
      wr(7'h00, 8'h07);
      runs(0, 16'h0001, 16'h0001);
      rd(7'h00, 8'h07);
      wr(7'h01, 8'h00);
      wr(7'h02, 8'h00);
      runs(0, 16'h0004, 16'h0003);
      wr24(OFS_B[6:0], 24'h000006);
      runs(1, 16'h0003, 16'h0003);
      wr24(OFS_C[6:0], 24'h000009);
      runs(2, 16'h0005, 16'h0004);
      wr24(OFS_D[6:0], 24'h000029);
      runs(3, 16'h0015, 16'h0014);
      $display("test dividers done");
      frame(1'b1, SEL_A, 1'b0, 1'b0, 1'b1, 16'h0007);
      frame(1'b1, SEL_B, 1'b1, 1'b0, 1'b0, 16'h0006);
      frame(1'b1, SEL_C, 1'b0, 1'b1, 1'b1, 16'h0009);
      frame(1'b1, SEL_C, 1'b1, 1'b1, 1'b0, 16'h0009);
      frame(1'b0, SEL_A, 1'b0, 1'b0, 1'b0, 16'h0007);
      frame(1'b0, SEL_B, 1'b0, 1'b0, 1'b1, 16'h0006);
      // D must run as a clock again before it can pace C's frames
      wr24(OFS_D[6:0], 24'h000029);
      repeat (64) @(posedge mclk);
      frame(1'b0, SEL_D, 1'b1, 1'b0, 1'b1, 16'h0029);
      // Reserved selector must leave the pin at rest
      wr24(OFS_C[6:0], {MODE_FRAME, 4'h2, 16'h0003});
      repeat (20) @(posedge mclk);
      snap = rises[2];
      repeat (200) @(posedge mclk);
      chk("reserved rises", {16'h0000, rises[2]}, {16'h0000, snap});
      chk("reserved level", {31'h0, outs[2]}, 32'h0);
      $display("test frames done");
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      rd(PAGE_ADDR, 8'h00);
      wr(PAGE_ADDR, 8'h01);
      rd24(OFS_C[6:0], RST_CD);
      $display("test second_reset done");
      close_out();
   end
endmodule
